// [cocr_regs.sv]
// Clock output configuration register bank, top level
`timescale 1ns/1ns
`default_nettype none
module cocr_regs
   import cocr_pkg::*;
   #(parameter int unsigned NUM_LANES = 8)
   (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Serial configuration port
   input wire logic spi_sclk_i,
   input wire logic spi_csn_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   // Configuration pins
   input wire logic synth_enable_pin_i,
   input wire logic single_ended_ref_select_pin_i,
   input wire logic clock_config_pin_zero_i,
   input wire logic clock_config_pin_one_i,
   input wire logic timestamp_input_pin_i,
   // Serializer status
   input wire logic serializer_reinit_i,
   // Synthesizer controls
   output logic synth_enable_o,
   output logic se_ref_select_o,
   output logic [1:0] first_divided_ref_output_o,
   output logic [1:0] second_divided_ref_output_o,
   output logic [COCR_BIAS_MSB:0] oscillator_bias_level_o,
   // Serial lanes
   output logic [NUM_LANES*COCR_PE_W-1:0] lane_preemphasis_level_o,
   // Auxiliary output
   output logic aux_output_enable_o,
   output logic aux_output_pin_o,
   output logic receiver_ref_clock_o
   );

   localparam logic [COCR_NUM_REGS-1:0][COCR_ADDR_W-1:0] REG_ADDR =
      {COCR_ADDR_OVR, COCR_ADDR_AUX, COCR_ADDR_PE, COCR_ADDR_BIAS};
   localparam logic [COCR_NUM_REGS-1:0][COCR_DATA_W-1:0] REG_RST =
      {COCR_RST_OVR, COCR_RST_AUX, COCR_RST_PE, COCR_RST_BIAS};

   logic [COCR_NUM_REGS-1:0][COCR_DATA_W-1:0] reg_q;
   logic slv_wr;
   logic [COCR_ADDR_W-1:0] slv_addr;
   logic [COCR_DATA_W-1:0] slv_wdata;
   logic [COCR_DATA_W-1:0] slv_rdata;
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   logic pin_en_s;
   logic pin_se_s;
   logic [1:0] pin_cfg_s;
   logic tstamp_s;
   logic ovr;
   logic aux_en;
   logic [COCR_AUX_MODE_MSB:0] aux_mode;
   logic aux_clk_mode;
   logic div_run;
   logic div_clk;
   logic [COCR_DIV_W-1:0] div_half;
   logic [1:0] next_first;
   logic [1:0] next_second;

   // ==========================================================
   // Serial port slave
   cocr_spi_slave u_spi (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .spi_sclk_i(spi_sclk_i),
      .spi_csn_i(spi_csn_i),
      .spi_sdi_i(spi_sdi_i),
      .spi_sdo_o(spi_sdo_o),
      .spi_sdo_oe_o(spi_sdo_oe_o),
      .wr_o(slv_wr),
      .addr_o(slv_addr),
      .wdata_o(slv_wdata),
      .rdata_i(slv_rdata)
   );

   // ==========================================================
   // Register storage
   for (genvar r = 0; r < COCR_NUM_REGS; r++)
   begin : g_reg
      always_ff @(posedge clk_sys_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            reg_q[r] <= REG_RST[r];
         end
         else if (slv_wr && slv_addr == REG_ADDR[r])
         begin
            reg_q[r] <= slv_wdata;
         end
      end
   end

   // ==========================================================
   // Read back
   always_comb
   begin
      slv_rdata = COCR_RD_UNMAPPED;
      for (int r = 0; r < COCR_NUM_REGS; r++)
      begin
         if (slv_addr == REG_ADDR[r])
         begin
            slv_rdata = reg_q[r];
         end
      end
   end

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end
      else
      begin
         pin_s1 <= {timestamp_input_pin_i, clock_config_pin_one_i,
                    clock_config_pin_zero_i, single_ended_ref_select_pin_i,
                    synth_enable_pin_i};
         pin_s2 <= pin_s1;
      end
   end

   assign pin_en_s = pin_s2[0];
   assign pin_se_s = pin_s2[1];
   assign pin_cfg_s = pin_s2[3:2];
   assign tstamp_s = pin_s2[4];

   // ==========================================================
   // Synthesizer control selection
   assign ovr = reg_q[COCR_IDX_OVR][COCR_OVR_EN_BIT];

   always_comb
   begin
      if (ovr)
      begin
         next_first =
            reg_q[COCR_IDX_OVR][COCR_FIRST_MSB:COCR_FIRST_LSB];
         next_second =
            reg_q[COCR_IDX_OVR][COCR_SECOND_MSB:COCR_SECOND_LSB];
      end
      else
      begin
         next_first = pin_cfg_s;
         next_second = pin_cfg_s;
      end
      if (next_first == COCR_REF_OFF)
      begin
         next_second = COCR_REF_OFF;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         synth_enable_o <= 1'b0;
         se_ref_select_o <= 1'b0;
         first_divided_ref_output_o <= COCR_REF_OFF;
         second_divided_ref_output_o <= COCR_REF_OFF;
      end
      else
      begin
         synth_enable_o <= ovr ?
            reg_q[COCR_IDX_OVR][COCR_SYN_EN_BIT] : pin_en_s;
         se_ref_select_o <= ovr ?
            reg_q[COCR_IDX_OVR][COCR_SE_REF_BIT] : pin_se_s;
         first_divided_ref_output_o <= next_first;
         second_divided_ref_output_o <= next_second;
      end
   end

   // ==========================================================
   // Bias and lane pre-emphasis
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         oscillator_bias_level_o <= COCR_RST_BIAS[COCR_BIAS_MSB:0];
      end
      else
      begin
         oscillator_bias_level_o <= reg_q[COCR_IDX_BIAS][COCR_BIAS_MSB:0];
      end
   end

   for (genvar l = 0; l < NUM_LANES; l++)
   begin : g_lane
      always_ff @(posedge clk_sys_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            lane_preemphasis_level_o[l*COCR_PE_W +: COCR_PE_W] <=
               COCR_RST_PE[COCR_PE_MSB:0];
         end
         else
         begin
            lane_preemphasis_level_o[l*COCR_PE_W +: COCR_PE_W] <=
               reg_q[COCR_IDX_PE][COCR_PE_MSB:0];
         end
      end
   end

   // ==========================================================
   // Auxiliary output
   assign aux_en = reg_q[COCR_IDX_AUX][COCR_AUX_EN_BIT];
   assign aux_mode = reg_q[COCR_IDX_AUX][COCR_AUX_MODE_MSB:0];
   assign aux_clk_mode = aux_mode <= COCR_AUX_UI64;
   assign div_run = aux_en && aux_clk_mode && !serializer_reinit_i;

   always_comb
   begin
      case (aux_mode)
         COCR_AUX_UI16: div_half = COCR_HALF_UI16;
         COCR_AUX_UI32: div_half = COCR_HALF_UI32;
         default: div_half = COCR_HALF_UI64;
      endcase
   end

   cocr_clk_div #(.CNT_W(COCR_DIV_W)) u_div (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .run_i(div_run),
      .half_period_i(div_half),
      .clk_o(div_clk)
   );

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aux_output_enable_o <= 1'b0;
         aux_output_pin_o <= 1'b0;
         receiver_ref_clock_o <= 1'b0;
      end
      else
      begin
         aux_output_enable_o <= aux_en;
         receiver_ref_clock_o <= aux_en && aux_clk_mode;
         if (!aux_en)
         begin
            aux_output_pin_o <= 1'b0;
         end
         else if (aux_clk_mode)
         begin
            aux_output_pin_o <= div_clk;
         end
         else if (aux_mode == COCR_AUX_TSTAMP)
         begin
            aux_output_pin_o <= tstamp_s;
         end
         else
         begin
            aux_output_pin_o <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_reinit_hit;
      serializer_reinit_i && aux_en && aux_clk_mode
      ##1 aux_en && aux_clk_mode;
   endsequence

   a_aux_reinit_stop: assert property (
      s_reinit_hit |=> !aux_output_pin_o)
      else $error("aux clock not stopped by serializer reinit");
   a_second_needs_first: assert property (
      second_divided_ref_output_o != COCR_REF_OFF
      |-> first_divided_ref_output_o != COCR_REF_OFF)
      else $error("second reference runs without first");
   a_synth_en_select: assert property (synth_enable_o ==
      ($past(ovr) ? $past(reg_q[COCR_IDX_OVR][COCR_SYN_EN_BIT])
                  : $past(pin_en_s)))
      else $error("synth enable source wrong");
   a_se_ref_select: assert property (se_ref_select_o ==
      ($past(ovr) ? $past(reg_q[COCR_IDX_OVR][COCR_SE_REF_BIT])
                  : $past(pin_se_s)))
      else $error("single-ended ref select source wrong");
   a_first_ref_pins: assert property (!$past(ovr)
      |-> first_divided_ref_output_o == $past(pin_cfg_s))
      else $error("first reference not from pins");
   a_first_ref_ovr: assert property ($past(ovr) |->
      first_divided_ref_output_o ==
      $past(reg_q[COCR_IDX_OVR][COCR_FIRST_MSB:COCR_FIRST_LSB]))
      else $error("first reference not from register");
   a_second_ref_ovr: assert property ($past(ovr) &&
      $past(next_first) != COCR_REF_OFF |-> second_divided_ref_output_o ==
      $past(reg_q[COCR_IDX_OVR][COCR_SECOND_MSB:COCR_SECOND_LSB]))
      else $error("second reference not from register");
   a_second_ref_pins: assert property (!$past(ovr) &&
      $past(pin_cfg_s) != COCR_REF_OFF
      |-> second_divided_ref_output_o == $past(pin_cfg_s))
      else $error("second reference not from pins");
   a_lanes_common: assert property (lane_preemphasis_level_o ==
      {NUM_LANES{lane_preemphasis_level_o[COCR_PE_MSB:0]}})
      else $error("lane pre-emphasis differs");
   a_aux_off_low: assert property (!aux_en |=>
      !aux_output_pin_o && !aux_output_enable_o)
      else $error("aux output active while disabled");
   a_aux_tstamp: assert property (
      aux_en && aux_mode == COCR_AUX_TSTAMP
      |=> aux_output_pin_o == $past(tstamp_s))
      else $error("timestamp not passed to aux output");
   a_rx_ref_mode: assert property (receiver_ref_clock_o ==
      $past(aux_en && aux_clk_mode))
      else $error("receiver reference flag wrong");
   a_reg_readback: assert property (
      slv_wr && slv_addr == COCR_ADDR_AUX
      |=> reg_q[COCR_IDX_AUX] == $past(slv_wdata))
      else $error("register did not take written value");

endmodule : cocr_regs
`default_nettype wire

// [cocr_pkg.sv]
// Shared constants of the clock output configuration register bank
package cocr_pkg;

   // ==========================================================
   // Serial port framing
   localparam int unsigned COCR_ADDR_W = 15;
   localparam int unsigned COCR_DATA_W = 8;
   localparam int unsigned COCR_CNT_W = 5;
   localparam logic [4:0] COCR_SPI_ADDR_DONE = 5'h10;
   localparam logic [4:0] COCR_SPI_FRAME_DONE = 5'h18;
   localparam int unsigned COCR_SPI_RW_BIT = 15;

   // ==========================================================
   // Register map
   localparam int unsigned COCR_NUM_REGS = 4;
   localparam int unsigned COCR_IDX_BIAS = 0;
   localparam int unsigned COCR_IDX_PE = 1;
   localparam int unsigned COCR_IDX_AUX = 2;
   localparam int unsigned COCR_IDX_OVR = 3;
   localparam logic [14:0] COCR_ADDR_BIAS = 15'h003f;
   localparam logic [14:0] COCR_ADDR_PE = 15'h0048;
   localparam logic [14:0] COCR_ADDR_AUX = 15'h0057;
   localparam logic [14:0] COCR_ADDR_OVR = 15'h0058;
   localparam logic [7:0] COCR_RST_BIAS = 8'h4f;
   localparam logic [7:0] COCR_RST_PE = 8'h00;
   localparam logic [7:0] COCR_RST_AUX = 8'h00;
   localparam logic [7:0] COCR_RST_OVR = 8'h00;
   localparam logic [7:0] COCR_RD_UNMAPPED = 8'h00;

   // ==========================================================
   // Field positions
   localparam int unsigned COCR_BIAS_MSB = 6;
   localparam int unsigned COCR_PE_MSB = 3;
   localparam int unsigned COCR_PE_W = 4;
   localparam int unsigned COCR_AUX_EN_BIT = 7;
   localparam int unsigned COCR_AUX_MODE_MSB = 2;
   localparam int unsigned COCR_OVR_EN_BIT = 7;
   localparam int unsigned COCR_SECOND_MSB = 5;
   localparam int unsigned COCR_SECOND_LSB = 4;
   localparam int unsigned COCR_FIRST_MSB = 3;
   localparam int unsigned COCR_FIRST_LSB = 2;
   localparam int unsigned COCR_SE_REF_BIT = 1;
   localparam int unsigned COCR_SYN_EN_BIT = 0;

   // ==========================================================
   // Codes
   localparam logic [2:0] COCR_AUX_UI16 = 3'h0;
   localparam logic [2:0] COCR_AUX_UI32 = 3'h1;
   localparam logic [2:0] COCR_AUX_UI64 = 3'h2;
   localparam logic [2:0] COCR_AUX_TSTAMP = 3'h3;
   localparam logic [1:0] COCR_REF_OFF = 2'h0;

   // ==========================================================
   // Auxiliary divider half periods, in system clock cycles
   localparam int unsigned COCR_DIV_W = 6;
   localparam logic [5:0] COCR_HALF_UI16 = 6'h08;
   localparam logic [5:0] COCR_HALF_UI32 = 6'h10;
   localparam logic [5:0] COCR_HALF_UI64 = 6'h20;

endpackage : cocr_pkg

// [cocr_clk_div.sv]
// Toggle divider for the auxiliary clock output
`timescale 1ns/1ns
`default_nettype none
module cocr_clk_div
   #(parameter int unsigned CNT_W = 6)
   (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Control
   input wire logic run_i,
   input wire logic [CNT_W-1:0] half_period_i,
   // Divided clock
   output logic clk_o
   );

   logic [CNT_W-1:0] cnt;

   // ==========================================================
   // Counter and toggle
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt <= '0;
         clk_o <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt <= '0;
         clk_o <= 1'b0;
      end
      else if (cnt == half_period_i - CNT_W'(1))
      begin
         cnt <= '0;
         clk_o <= !clk_o;
      end
      else
      begin
         cnt <= cnt + CNT_W'(1);
      end
   end

endmodule : cocr_clk_div
`default_nettype wire

// [cocr_spi_slave.sv]
// Serial configuration port slave
`timescale 1ns/1ns
`default_nettype none
module cocr_spi_slave
   import cocr_pkg::*;
   (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Serial pins
   input wire logic spi_sclk_i,
   input wire logic spi_csn_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   // Register side
   output logic wr_o,
   output logic [COCR_ADDR_W-1:0] addr_o,
   output logic [COCR_DATA_W-1:0] wdata_o,
   input wire logic [COCR_DATA_W-1:0] rdata_i
   );

   logic [2:0] sclk_sr;
   logic [1:0] csn_sr;
   logic [1:0] sdi_sr;
   logic [COCR_CNT_W-1:0] cnt;
   logic [23:0] shreg;
   logic [COCR_DATA_W-1:0] tx;
   logic rd;
   logic sclk_rise;
   logic sclk_fall;
   logic [23:0] next_shreg;
   logic [COCR_CNT_W-1:0] next_cnt;

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sclk_sr <= '0;
         csn_sr <= 2'h3;
         sdi_sr <= '0;
      end
      else
      begin
         sclk_sr <= {sclk_sr[1:0], spi_sclk_i};
         csn_sr <= {csn_sr[0], spi_csn_i};
         sdi_sr <= {sdi_sr[0], spi_sdi_i};
      end
   end

   assign sclk_rise = sclk_sr[1] && !sclk_sr[2];
   assign sclk_fall = !sclk_sr[1] && sclk_sr[2];
   assign next_shreg = {shreg[22:0], sdi_sr[1]};
   assign next_cnt = cnt + COCR_CNT_W'(1);

   // ==========================================================
   // Receive shifter and decode
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt <= '0;
         shreg <= '0;
         rd <= 1'b0;
         wr_o <= 1'b0;
         addr_o <= '0;
         wdata_o <= '0;
      end
      else
      begin
         wr_o <= 1'b0;
         if (csn_sr[1])
         begin
            cnt <= '0;
            rd <= 1'b0;
         end
         else if (sclk_rise && cnt != COCR_SPI_FRAME_DONE)
         begin
            shreg <= next_shreg;
            cnt <= next_cnt;
            if (next_cnt == COCR_SPI_ADDR_DONE)
            begin
               addr_o <= next_shreg[COCR_ADDR_W-1:0];
               rd <= next_shreg[COCR_SPI_RW_BIT];
            end
            if (next_cnt == COCR_SPI_FRAME_DONE && !rd)
            begin
               wr_o <= 1'b1;
               wdata_o <= next_shreg[COCR_DATA_W-1:0];
            end
         end
      end
   end

   // ==========================================================
   // Read data shifter
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tx <= '0;
         spi_sdo_o <= 1'b0;
         spi_sdo_oe_o <= 1'b0;
      end
      else
      begin
         spi_sdo_oe_o <= !csn_sr[1] && rd;
         if (csn_sr[1])
         begin
            spi_sdo_o <= 1'b0;
         end
         else if (sclk_fall && rd && cnt == COCR_SPI_ADDR_DONE)
         begin
            spi_sdo_o <= rdata_i[COCR_DATA_W-1];
            tx <= {rdata_i[COCR_DATA_W-2:0], 1'b0};
         end
         else if (sclk_fall && rd)
         begin
            spi_sdo_o <= tx[COCR_DATA_W-1];
            tx <= {tx[COCR_DATA_W-2:0], 1'b0};
         end
      end
   end

endmodule : cocr_spi_slave
`default_nettype wire

// [cocr_regs_tb.sv]
// Self-checking bench for the clock output configuration register bank
`timescale 1ns/1ns
`default_nettype none
module cocr_regs_tb
   import cocr_pkg::*;
   ;
   // =====================================================
   // Signals
   localparam int TIMEOUT_CYC = 30000;
   // Synthesizer programming reset register, outside this bank
   localparam logic [14:0] SYNTH_PROG_RST_ADDR = 15'h005c;
   logic clk_sys, arst_n, sclk, csn, sdi, sdo, sdo_oe;
   logic en_pin, se_pin, cfg0, cfg1, ts_pin, reinit;
   logic syn_en, se_sel, aux_en, aux_pin, rx_clk;
   logic [1:0] first_ref, second_ref;
   logic [6:0] bias;
   logic [31:0] pe;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;

   // =====================================================
   // Design
   cocr_regs #(.NUM_LANES(8)) dut (
      .clk_sys_i(clk_sys), .arst_n_i(arst_n),
      .spi_sclk_i(sclk), .spi_csn_i(csn), .spi_sdi_i(sdi),
      .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
      .synth_enable_pin_i(en_pin), .single_ended_ref_select_pin_i(se_pin),
      .clock_config_pin_zero_i(cfg0), .clock_config_pin_one_i(cfg1),
      .timestamp_input_pin_i(ts_pin), .serializer_reinit_i(reinit),
      .synth_enable_o(syn_en), .se_ref_select_o(se_sel),
      .first_divided_ref_output_o(first_ref),
      .second_divided_ref_output_o(second_ref),
      .oscillator_bias_level_o(bias), .lane_preemphasis_level_o(pe),
      .aux_output_enable_o(aux_en), .aux_output_pin_o(aux_pin),
      .receiver_ref_clock_o(rx_clk));

   // =====================================================
   // Clock and watchdog
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == TIMEOUT_CYC)
      begin
         errors++;
         $display("[FAIL] watchdog expected end seen timeout");
         report_and_stop();
      end
   end

   // =====================================================
   // Tasks
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task automatic cyc_wait(input int k);
      repeat (k) @(negedge clk_sys);
   endtask : cyc_wait

   task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tdone(input string name);
      $display("Test %s finished", name);
   endtask : tdone

   // One 24-bit frame, sclk phases of 6 cycles each
   task automatic spi(input logic rd, input logic [14:0] addr,
      input logic [7:0] wdat, output logic [7:0] rdat);
      logic [23:0] frame;
      frame = {rd, addr, wdat};
      rdat = 8'h00;
      csn = 1'b0;
      cyc_wait(6);
      for (int i = 23; i >= 0; i--)
      begin
         sdi = frame[i];
         cyc_wait(6);
         if (i < 8)
         begin
            rdat[i] = sdo;
            chk("sdo_oe", rd, sdo_oe);
         end
         sclk = 1'b1;
         cyc_wait(6);
         sclk = 1'b0;
      end
      cyc_wait(6);
      csn = 1'b1;
      cyc_wait(8);
   endtask : spi

   task automatic wr(input logic [14:0] addr, input logic [7:0] d);
      logic [7:0] r;
      spi(1'b0, addr, d, r);
   endtask : wr

   task automatic rdchk(input string name, input logic [14:0] addr,
      input logic [7:0] exp);
      logic [7:0] r;
      spi(1'b1, addr, 8'h00, r);
      chk(name, exp, r);
   endtask : rdchk

   // Cycles between two toggles of the aux pin, 200 if none
   task automatic half_per(output int cnt);
      logic v;
      int k;
      v = aux_pin;
      k = 0;
      while (aux_pin === v && k < 200)
      begin
         cyc_wait(1);
         k++;
      end
      v = aux_pin;
      cnt = 0;
      while (aux_pin === v && cnt < 200)
      begin
         cyc_wait(1);
         cnt++;
      end
   endtask : half_per

   // =====================================================
   // Sequence
   initial
   begin
      sclk = 1'b0;
      csn = 1'b1;
      sdi = 1'b0;
      en_pin = 1'b0;
      se_pin = 1'b0;
      cfg0 = 1'b0;
      cfg1 = 1'b0;
      ts_pin = 1'b0;
      reinit = 1'b0;
      arst_n = 1'b0;
      cyc_wait(12);
      arst_n = 1'b1;
      cyc_wait(2);
      chk("bias_out_rst", 32'h0000_004f, bias);
      chk("pe_out_rst", 32'h0000_0000, pe);
      rdchk("bias_rst", COCR_ADDR_BIAS, 8'h4f);
      rdchk("pe_rst", COCR_ADDR_PE, 8'h00);
      rdchk("aux_rst", COCR_ADDR_AUX, 8'h00);
      rdchk("ovr_rst", COCR_ADDR_OVR, 8'h00);
      tdone("reset_values");

      wr(SYNTH_PROG_RST_ADDR, 8'h01);
      wr(COCR_ADDR_BIAS, 8'h4a);
      wr(SYNTH_PROG_RST_ADDR, 8'h00);
      rdchk("bias_rb", COCR_ADDR_BIAS, 8'h4a);
      chk("bias_out", 32'h0000_004a, bias);
      wr(COCR_ADDR_PE, 8'h0b);
      rdchk("pe_rb", COCR_ADDR_PE, 8'h0b);
      chk("pe_lanes", 32'hbbbb_bbbb, pe);
      wr(15'h0049, 8'h55);
      rdchk("unmapped", 15'h0049, 8'h00);
      rdchk("pe_kept", COCR_ADDR_PE, 8'h0b);
      tdone("readback");

      for (int m = 0; m < 8; m++)
      begin
         wr(COCR_ADDR_AUX, m[7:0]);
         chk("aux_en_off", 1'b0, aux_en);
         chk("aux_pin_off", 1'b0, aux_pin);
         wr(COCR_ADDR_AUX, 8'h80 | m[7:0]);
         rdchk("aux_rb", COCR_ADDR_AUX, 8'h80 | m[7:0]);
         chk("aux_en_on", 1'b1, aux_en);
         chk("rx_clk", m < 3, rx_clk);
         if (m == 3)
         begin
            ts_pin = 1'b1;
            cyc_wait(6);
            chk("tstamp_hi", 1'b1, aux_pin);
            ts_pin = 1'b0;
            cyc_wait(6);
            chk("tstamp_lo", 1'b0, aux_pin);
         end
         else
         begin
            half_per(n);
            chk("half_period", (m < 3) ? (8 << m) : 200, n);
         end
         wr(COCR_ADDR_AUX, m[7:0]);
      end
      tdone("aux_modes");

      wr(COCR_ADDR_AUX, 8'h00);
      wr(COCR_ADDR_AUX, 8'h80);
      reinit = 1'b1;
      cyc_wait(4);
      half_per(n);
      chk("reinit_stop", 200, n);
      chk("reinit_pin", 1'b0, aux_pin);
      reinit = 1'b0;
      half_per(n);
      chk("reinit_run", 8, n);
      tdone("serializer_reinit");

      en_pin = 1'b1;
      se_pin = 1'b1;
      cfg1 = 1'b1;
      cyc_wait(5);
      chk("pin_syn", 1'b1, syn_en);
      chk("pin_se", 1'b1, se_sel);
      chk("pin_first", 2'h2, first_ref);
      wr(COCR_ADDR_OVR, 8'h30);
      chk("pin_second", 2'h2, second_ref);
      wr(COCR_ADDR_OVR, 8'h9e);
      chk("ovr_syn", 1'b0, syn_en);
      chk("ovr_se", 1'b1, se_sel);
      chk("ovr_first", 2'h3, first_ref);
      chk("ovr_second", 2'h1, second_ref);
      wr(COCR_ADDR_OVR, 8'hb1);
      chk("ovr_syn1", 1'b1, syn_en);
      chk("ovr_se0", 1'b0, se_sel);
      chk("gate_first", 2'h0, first_ref);
      chk("gate_second", 2'h0, second_ref);
      wr(COCR_ADDR_OVR, 8'h00);
      en_pin = 1'b0;
      cyc_wait(5);
      chk("pin_syn0", 1'b0, syn_en);
      tdone("override");
      report_and_stop();
   end
endmodule : cocr_regs_tb
`default_nettype wire
